// ===== hw/rsr_pkg.sv
// rsr_pkg: shared constants and types for the serial read path.
// assumes: one clock domain (mclk); bus pins sampled through rsr_sync.
package rsr_pkg;

  // ----------------------------------------------------------------
  // slave addressing
  // ----------------------------------------------------------------
  localparam logic [6:0]  ARRAY_ID   = 7'h57;
  localparam logic [6:0]  CCR_ID     = 7'h6F;

  // ----------------------------------------------------------------
  // address counter
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 16;
  localparam logic [15:0] ADDR_RST   = 16'h0000;
  localparam logic [15:0] ADDR_LAST  = 16'hFFFF;
  localparam logic [15:0] ADDR_STEP  = 16'h0001;

  // ----------------------------------------------------------------
  // byte framing
  // ----------------------------------------------------------------
  localparam logic [3:0]  BIT_LAST   = 4'h7;
  localparam logic [3:0]  BIT_DONE   = 4'h8;
  localparam logic [3:0]  BIT_STEP   = 4'h1;
  localparam logic [1:0]  WORD_HI    = 2'h0;
  localparam logic [1:0]  WORD_LO    = 2'h1;
  localparam logic [1:0]  WORD_DATA  = 2'h2;
  localparam logic [1:0]  WORD_STEP  = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_RX_SLAVE  = 3'b001,
    ST_ACK_SLAVE = 3'b010,
    ST_RX_WORD   = 3'b011,
    ST_ACK_WORD  = 3'b100,
    ST_TX_DATA   = 3'b101,
    ST_RX_MACK   = 3'b110,
    ST_WAIT_BUS  = 3'b111
  } rsr_state_e;

endpackage

// ===== hw/rsr_sync.sv
// rsr_sync: two-flop synchroniser for a group of asynchronous levels.
// assumes: inputs are idle-high bus lines; reset already released in mclk.
`timescale 1ns/1ps
module rsr_sync #(
  parameter int         WIDTH = 2,
  parameter logic [1:0] IDLE  = 2'h3
) (
  input  wire logic             mclk,
  input  wire logic             rstSync_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] safe;
  } rsr_sync_s;

  rsr_sync_s r;
  rsr_sync_s next_r;

  // first stage is read only by the second stage
  always_comb begin
    next_r.meta = din;
    next_r.safe = r.meta;
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      r <= {IDLE, IDLE};
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.safe;

endmodule // rsr_sync

// ===== hw/rsr_read_path.sv
// rsr_read_path: two-wire slave read side with the read address counter.
// assumes: bus master drives scl; storage answers rdData within 4 mclk of rdAddr.
// Functional notes
// - the counter holds one past the last location read, so the next read gets the next word.
// - reset clears the sixteen-bit counter to zero.
// - a matching slave byte with read direction is acknowledged, then eight data bits are driven from the counter.
// - a random read starts with a dummy write of slave byte and word address bytes, each acknowledged.
// - after a repeated start and slave byte with read set, the device acknowledges and returns the addressed byte.
// - a stop after the word address loads it into the counter and the device ignores the bus until a start.
// - the next current-address read after a loaded address returns data from exactly that address.
// - each master acknowledge of a read byte makes the device send the byte at the next address.
// - the counter crosses page and column boundaries without page wrapping.
// - past the last location the counter wraps to the first and reading goes on.
// - only a slave byte whose top seven bits match the array or control pattern is acknowledged.
// - two word address bytes follow the slave byte when an address is supplied.
// - after a byte the line is released and sampled; without an acknowledge no more data is driven.
`timescale 1ns/1ps
module rsr_read_path #(
  parameter logic [15:0] ADDR_TOP = rsr_pkg::ADDR_LAST
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic [15:0]      rdAddr,
  output logic             rdCcr,
  input  wire logic [7:0]  rdData
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic       rstMeta_n;
  logic       rstSync_n;
  logic [1:0] pinSync;
  logic       sclS;
  logic       sdaS;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  rsr_sync #(.WIDTH(2), .IDLE(2'h3)) uSync (
    .mclk      (mclk),
    .rstSync_n (rstSync_n),
    .din       ({sclIn, sdaIn}),
    .dout      (pinSync)
  );

  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rsr_pkg::rsr_state_e st;
    logic                sclP;
    logic                sdaP;
    logic [3:0]          bitCnt;
    logic [7:0]          shift;
    logic [1:0]          wordIdx;
    logic                rdDir;
    logic                ccrSel;
    logic                holdValid;
    logic [15:0]         pendAddr;
    logic [15:0]         addrCnt;
    logic                mack;
    logic                sdaOe;
    logic                sdaOut;
  } rsr_regs_s;

  rsr_regs_s r;
  rsr_regs_s next_r;

  logic       sclRise;
  logic       sclFall;
  logic       busStart;
  logic       busStop;
  logic [7:0] rxByte;

  assign sclRise  = sclS & ~r.sclP;
  assign sclFall  = ~sclS & r.sclP;
  assign busStart = sclS & r.sclP & r.sdaP & ~sdaS;
  assign busStop  = sclS & r.sclP & ~r.sdaP & sdaS;
  assign rxByte   = {r.shift[6:0], sdaS};

  always_comb begin
    next_r      = r;
    next_r.sclP = sclS;
    next_r.sdaP = sdaS;
    if (busStart || busStop) begin
      next_r.st     = busStart ? rsr_pkg::ST_RX_SLAVE : rsr_pkg::ST_IDLE;
      next_r.bitCnt = 4'h0;
      next_r.sdaOe  = 1'b0;
      if (r.holdValid) begin
        next_r.addrCnt   = r.pendAddr;
        next_r.holdValid = 1'b0;
      end
    end else begin
      case (r.st)
        rsr_pkg::ST_RX_SLAVE: begin
          if (sclRise) begin
            next_r.shift  = rxByte;
            next_r.bitCnt = r.bitCnt + rsr_pkg::BIT_STEP;
            if (r.bitCnt == rsr_pkg::BIT_LAST) begin
              if (rxByte[7:1] == rsr_pkg::ARRAY_ID || rxByte[7:1] == rsr_pkg::CCR_ID) begin
                next_r.st     = rsr_pkg::ST_ACK_SLAVE;
                next_r.ccrSel = (rxByte[7:1] == rsr_pkg::CCR_ID);
                next_r.rdDir  = rxByte[0];
              end else begin
                next_r.st = rsr_pkg::ST_WAIT_BUS;
              end
            end
          end
        end
        rsr_pkg::ST_ACK_SLAVE: begin
          if (sclFall) begin
            if (!r.sdaOe) begin
              next_r.sdaOe = 1'b1;
            end else if (r.rdDir) begin
              next_r.shift  = rdData;
              next_r.sdaOe  = ~rdData[7];
              next_r.bitCnt = 4'h0;
              next_r.st     = rsr_pkg::ST_TX_DATA;
            end else begin
              next_r.sdaOe   = 1'b0;
              next_r.bitCnt  = 4'h0;
              next_r.wordIdx = rsr_pkg::WORD_HI;
              next_r.st      = rsr_pkg::ST_RX_WORD;
            end
          end
        end
        rsr_pkg::ST_RX_WORD: begin
          if (sclRise) begin
            next_r.shift  = rxByte;
            next_r.bitCnt = r.bitCnt + rsr_pkg::BIT_STEP;
            if (r.bitCnt == rsr_pkg::BIT_LAST) begin
              next_r.st = rsr_pkg::ST_ACK_WORD;
              if (r.wordIdx == rsr_pkg::WORD_HI) begin
                next_r.pendAddr[15:8] = rxByte;
              end else if (r.wordIdx == rsr_pkg::WORD_LO) begin
                next_r.pendAddr[7:0] = rxByte;
                next_r.holdValid     = 1'b1;
              end else begin
                // a data byte belongs to the write path; no address load then
                next_r.holdValid = 1'b0;
              end
            end
          end
        end
        rsr_pkg::ST_ACK_WORD: begin
          if (sclFall) begin
            if (!r.sdaOe) begin
              next_r.sdaOe = 1'b1;
            end else begin
              next_r.sdaOe  = 1'b0;
              next_r.bitCnt = 4'h0;
              next_r.st     = rsr_pkg::ST_RX_WORD;
              if (r.wordIdx != rsr_pkg::WORD_DATA) begin
                next_r.wordIdx = r.wordIdx + rsr_pkg::WORD_STEP;
              end
            end
          end
        end
        rsr_pkg::ST_TX_DATA: begin
          if (sclRise) begin
            next_r.bitCnt = r.bitCnt + rsr_pkg::BIT_STEP;
            if (r.bitCnt == rsr_pkg::BIT_LAST) begin
              next_r.addrCnt = (r.addrCnt == ADDR_TOP) ? rsr_pkg::ADDR_RST : r.addrCnt + rsr_pkg::ADDR_STEP;
            end
          end else if (sclFall) begin
            // msb first, change while scl low
            if (r.bitCnt == rsr_pkg::BIT_DONE) begin
              next_r.sdaOe = 1'b0;
              next_r.st    = rsr_pkg::ST_RX_MACK;
            end else begin
              next_r.shift = {r.shift[6:0], 1'b0};
              next_r.sdaOe = ~r.shift[6];
            end
          end
        end
        rsr_pkg::ST_RX_MACK: begin
          if (sclRise) begin
            if (sdaS) begin
              next_r.st = rsr_pkg::ST_WAIT_BUS;
            end else begin
              next_r.mack = 1'b1;
            end
          end else if (sclFall && r.mack) begin
            next_r.mack   = 1'b0;
            next_r.shift  = rdData;
            next_r.sdaOe  = ~rdData[7];
            next_r.bitCnt = 4'h0;
            next_r.st     = rsr_pkg::ST_TX_DATA;
          end
        end
        default: begin
          next_r.sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      r <= '{st: rsr_pkg::ST_IDLE, sclP: 1'b1, sdaP: 1'b1, bitCnt: 4'h0, shift: 8'h00, wordIdx: 2'h0,
             rdDir: 1'b0, ccrSel: 1'b0, holdValid: 1'b0, pendAddr: 16'h0000,
             addrCnt: rsr_pkg::ADDR_RST, mack: 1'b0, sdaOe: 1'b0, sdaOut: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign sdaOut = r.sdaOut;
  assign sdaOe  = r.sdaOe;
  assign rdAddr = r.addrCnt;
  assign rdCcr  = r.ccrSel;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  counter_reset_a: assert property (@(posedge mclk) $rose(rstSync_n) |-> r.addrCnt == rsr_pkg::ADDR_RST)
    else $error("counter not zero after reset");

  counter_step_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
    (r.st == rsr_pkg::ST_TX_DATA && sclRise && r.bitCnt == rsr_pkg::BIT_LAST && !busStart && !busStop
     && r.addrCnt != ADDR_TOP) |=> r.addrCnt == $past(r.addrCnt) + rsr_pkg::ADDR_STEP)
    else $error("counter did not advance after a byte");

  counter_wrap_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
    (r.st == rsr_pkg::ST_TX_DATA && sclRise && r.bitCnt == rsr_pkg::BIT_LAST && !busStart && !busStop
     && r.addrCnt == ADDR_TOP) |=> r.addrCnt == rsr_pkg::ADDR_RST)
    else $error("counter did not wrap");

  stop_load_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
    (busStop && r.holdValid) |=> (r.addrCnt == $past(r.pendAddr)) && r.st == rsr_pkg::ST_IDLE && !r.holdValid)
    else $error("stop did not load address");

  slave_match_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
    (r.st == rsr_pkg::ST_RX_SLAVE && sclRise && r.bitCnt == rsr_pkg::BIT_LAST && !busStart && !busStop
     && rxByte[7:1] != rsr_pkg::ARRAY_ID && rxByte[7:1] != rsr_pkg::CCR_ID) |=> r.st == rsr_pkg::ST_WAIT_BUS)
    else $error("unmatched slave byte accepted");

  nack_release_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
    (r.st == rsr_pkg::ST_RX_MACK && sclRise && sdaS && !busStart && !busStop)
    |=> (r.st == rsr_pkg::ST_WAIT_BUS && !r.sdaOe) [*2])
    else $error("data driven after missing acknowledge");

  mack_next_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
    (r.st == rsr_pkg::ST_RX_MACK && r.mack && sclFall && !busStart && !busStop)
    |=> r.st == rsr_pkg::ST_TX_DATA && r.sdaOe == ~$past(rdData[7]) && r.bitCnt == 4'h0)
    else $error("acknowledged byte not followed by next byte");

  sda_low_change_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
    $changed(r.sdaOe) |-> !sclS)
    else $error("data line changed while scl high");

  idle_quiet_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
    (r.st == rsr_pkg::ST_IDLE || r.st == rsr_pkg::ST_WAIT_BUS) |-> !r.sdaOe && !r.sdaOut)
    else $error("bus driven in standby");

  read_ack_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
    (r.st == rsr_pkg::ST_ACK_SLAVE && r.sdaOe && r.rdDir && sclFall && !busStart && !busStop)
    |=> r.st == rsr_pkg::ST_TX_DATA && r.shift == $past(rdData))
    else $error("read did not start from counter data");

endmodule // rsr_read_path

// ===== bench/rsr_master.sv
// rsr_master: behavioural two-wire bus master that drives the read path.
// assumes: the bench resolves the open-drain sda; scl phases last 4 mclk.
`timescale 1ns/1ps
module rsr_master (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaLow
);
  // ----------------------------------------------------------------
  // bus timing helpers
  // ----------------------------------------------------------------
  // scl idles high and only toggles inside frames
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic half();
    repeat (2) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // conditions and bytes
  // ----------------------------------------------------------------
  // start or repeated start
  task automatic start();
    half();
    sdaLow <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    half();
    sdaLow <= 1'b1;
    half();
    half();
    scl <= 1'b0;
  endtask

  task automatic stop();
    half();
    sdaLow <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    half();
    sdaLow <= 1'b0;
    half();
    half();
  endtask

  // nine bit slots
  // sda moves mid low phase so it never races an scl edge
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      half();
      sdaLow <= ~tx[i];
      half();
      scl <= 1'b1;
      half();
      half();
      rx[i] = sda;
      scl <= 1'b0;
    end
  endtask
endmodule // rsr_master

// ===== bench/rsr_read_path_tb_top.sv
// rsr_read_path_tb_top: self-checking bench for the serial read path.
// assumes: rsr_master stands in for the bus master; storage is a bench function.
`timescale 1ns/1ps
module rsr_read_path_tb_top;
  // small wrap point; the random read crosses it from TOP - 1
  localparam logic [15:0] TOP = 16'h01FF;
  logic        mclk, rst_n, scl, sdaLow, sdaOut, sdaOe, rdCcr, sclPrev, oePrev;
  logic [15:0] rdAddr, ptr;
  logic [7:0]  rdData;
  wire logic   sda;
  int          mismatches, checks;

  assign sda = ~((sdaOe & ~sdaOut) | sdaLow);

  rsr_read_path #(.ADDR_TOP(TOP)) dut (.mclk(mclk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .rdAddr(rdAddr), .rdCcr(rdCcr), .rdData(rdData));
  rsr_master m (.mclk(mclk), .sda(sda), .scl(scl), .sdaLow(sdaLow));

  // ----------------------------------------------------------------
  // clock, storage and helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [7:0] stored(input logic [15:0] a, input logic c);
    return a[7:0] ^ a[15:8] ^ (c ? 8'hA5 : 8'h00);
  endfunction

  function automatic logic [15:0] nxt(input logic [15:0] a);
    return (a == TOP) ? 16'h0000 : a + 16'h0001;
  endfunction

  always @(posedge mclk) rdData <= stored(rdAddr, rdCcr);

  // enable moves only with scl low
  always @(posedge mclk) begin
    if (rst_n && sclPrev && scl && sdaOe !== oePrev) begin
      mismatches++;
      $display("MISMATCH t=%0t sdaOe moved with scl high got=%h exp=%h", $time, sdaOe, oePrev);
    end
    sclPrev <= scl;
    oePrev  <= sdaOe;
  end

  task automatic note(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpData(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, {8'h00, got}, {8'h00, exp});
  endtask

  task automatic cmpAddr(input logic [15:0] got, input logic [15:0] exp);
    note(got === exp, got, exp);
  endtask

  task automatic cmpFlag(input logic got, input logic exp);
    note(got === exp, {15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus sequences
  // ----------------------------------------------------------------
  task automatic readRun(input logic [6:0] id, input int n);
    logic [8:0] rx;
    m.start();
    m.xfer({id, 1'b1, 1'b1}, rx);
    cmpFlag(rx[0], 1'b0);
    for (int i = 0; i < n; i++) begin
      m.xfer({8'hFF, i == n - 1}, rx);
      cmpData(rx[8:1], stored(ptr, id == rsr_pkg::CCR_ID));
      ptr = nxt(ptr);
    end
    m.stop();
    cmpAddr(rdAddr, ptr);
  endtask

  task automatic setAddr(input logic [6:0] id, input logic [15:0] a);
    logic [8:0] rx;
    m.start();
    m.xfer({id, 1'b0, 1'b1}, rx);
    cmpFlag(rx[0], 1'b0);
    m.xfer({a[15:8], 1'b1}, rx);
    cmpFlag(rx[0], 1'b0);
    m.xfer({a[7:0], 1'b1}, rx);
    cmpFlag(rx[0], 1'b0);
    ptr = a;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tPower();
    cmpAddr(rdAddr, 16'h0000);
    ptr = 16'h0000;
    readRun(rsr_pkg::ARRAY_ID, 1);
    cmpFlag(rdCcr, 1'b0);
    readRun(rsr_pkg::ARRAY_ID, 2);
    $display("done power-up reads");
  endtask

  task automatic tSetAddr();
    logic [8:0]  rx;
    logic [15:0] hold;
    setAddr(rsr_pkg::ARRAY_ID, 16'h00FE);
    m.stop();
    repeat (8) @(posedge mclk);
    cmpAddr(rdAddr, 16'h00FE);
    readRun(rsr_pkg::ARRAY_ID, 3);
    // a data byte after the address belongs to the write path: no load at stop
    hold = ptr;
    setAddr(rsr_pkg::ARRAY_ID, 16'h0155);
    m.xfer({8'h3C, 1'b1}, rx);
    cmpFlag(rx[0], 1'b0);
    m.stop();
    ptr = hold;
    repeat (8) @(posedge mclk);
    cmpAddr(rdAddr, ptr);
    $display("done set address");
  endtask

  task automatic tRandom();
    setAddr(rsr_pkg::ARRAY_ID, TOP - 16'h0001);
    readRun(rsr_pkg::ARRAY_ID, 4);
    setAddr(rsr_pkg::CCR_ID, 16'h0010);
    readRun(rsr_pkg::CCR_ID, 2);
    cmpFlag(rdCcr, 1'b1);
    $display("done random reads");
  endtask

  task automatic tRefuse();
    logic [6:0] bad [4];
    logic [8:0] rx;
    bad = '{7'h50, 7'h56, 7'h6E, 7'h77};
    foreach (bad[k]) begin
      m.start();
      m.xfer({bad[k], 1'b1, 1'b1}, rx);
      cmpFlag(rx[0], 1'b1);
      m.xfer({8'hFF, 1'b1}, rx);
      cmpData(rx[8:1], 8'hFF);
      m.stop();
      cmpAddr(rdAddr, ptr);
    end
    m.start();
    m.xfer({rsr_pkg::CCR_ID, 1'b1, 1'b1}, rx);
    m.xfer({8'hFF, 1'b1}, rx);
    cmpData(rx[8:1], stored(ptr, 1'b1));
    ptr = nxt(ptr);
    m.xfer({8'hFF, 1'b1}, rx);
    cmpData(rx[8:1], 8'hFF);
    m.stop();
    cmpAddr(rdAddr, ptr);
    $display("done refusals");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_n      = 1'b0;
    mismatches = 0;
    checks     = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    tPower();
    tSetAddr();
    tRandom();
    tRefuse();
    finish_test();
  end

  // runs take about 3300 mclk; a hang is cut off well beyond that
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test();
  end
endmodule // rsr_read_path_tb_top
